// *** core/tmr16_pkg.sv ***
package tmr16_pkg;

	// ==========================================================
	// Register byte addresses, one aligned word each
	localparam logic [7:0] OFF_CNT_LO = 8'h00;
	localparam logic [7:0] OFF_CNT_HI = 8'h04;
	localparam logic [7:0] OFF_CMPA_LO = 8'h08;
	localparam logic [7:0] OFF_CMPA_HI = 8'h0c;
	localparam logic [7:0] OFF_CMPB_LO = 8'h10;
	localparam logic [7:0] OFF_CMPB_HI = 8'h14;
	localparam logic [7:0] OFF_CAP_LO = 8'h18;
	localparam logic [7:0] OFF_CAP_HI = 8'h1c;
	localparam logic [7:0] OFF_CTRL_A = 8'h20;
	localparam logic [7:0] OFF_CTRL_B = 8'h24;
	localparam logic [7:0] OFF_FLAGS = 8'h28;
	localparam logic [7:0] OFF_MASK = 8'h2c;

	// ==========================================================
	// Field positions
	localparam int CTRLA_WGM_LO = 0;
	localparam int CTRLA_CAP_SRC = 2;
	localparam int CTRLA_OUT_A = 4;
	localparam int CTRLA_OUT_B = 6;
	localparam int CTRLB_CS = 0;
	localparam int CTRLB_WGM_HI = 3;
	localparam int CTRLB_EDGE = 6;
	localparam int CTRLB_FILT = 7;
	localparam int FLG_OVF = 0;
	localparam int FLG_MATCH_A = 1;
	localparam int FLG_MATCH_B = 2;
	localparam int FLG_CAP = 5;

	// ==========================================================
	// Values and counts
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [9:0] DIV8_MASK = 10'h007;
	localparam logic [9:0] DIV64_MASK = 10'h03f;
	localparam logic [9:0] DIV256_MASK = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK = 10'h3ff;
	localparam int FILT_LEN = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Whole state of the core
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic w_lane;
		logic [7:0] w_data;
		logic [15:0] count;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] buf_a;
		logic [15:0] buf_b;
		logic [15:0] cap;
		logic [7:0] temp;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [9:0] presc;
		logic ext_prev;
		logic [3:0] cap_hist;
		logic cap_lvl;
		logic wave_a;
		logic wave_b;
		logic irq;
		logic at_bottom;
		logic at_max;
	} tmr16_state_t;

endpackage : tmr16_pkg

// *** core/tmr16_core.sv ***
// Operation
// - Counter, compares, capture 16 bit; controls 8
// - One shared 8-bit high-byte holding register
// - Low-byte write loads holding plus byte
// - Low-byte read copies high byte into holding
// - Compare reads bypass the holding register
// - Clock select picks system, prescaler or pin
// - Compares checked against counter on each count tick
// - Compare match sets channel match flag
// - Compare drives waveform output pins
// - Flags visible, individually masked
// - Bottom at zero, max at all ones
// - Top fixed, compare A, or capture
// - Compare A as top gives no wave in PWM modes
// - Edge captures counter outside capture-top modes, optional noise filter
// - Software counter write beats count or clear
// - Capture flag set with capture copy
// - Capture writable only in capture-top modes
// - Select zero stops counter, stays accessible
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module tmr16_core #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_count_pin,
	input wire logic capture_pin,
	input wire logic comparator_in,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic irq_req,
	output logic at_bottom,
	output logic at_max
);

	tmr16_pkg::tmr16_state_t s_q, s_d;

	// ==========================================================
	// Mode decode
	logic [3:0] wgm;
	logic pwm_mode, icr_top, ocra_top, at_top;
	logic [15:0] top;
	assign wgm = {s_q.ctrl_b[tmr16_pkg::CTRLB_WGM_HI +: 2], s_q.ctrl_a[tmr16_pkg::CTRLA_WGM_LO +: 2]};
	assign icr_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
	assign ocra_top = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hb) || (wgm == 4'hf);
	assign pwm_mode = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hc) && (wgm != 4'hd);

	// Top value per mode
	always_comb
	begin
		unique case (wgm)
			4'h1, 4'h5: top = tmr16_pkg::TOP_8BIT;
			4'h2, 4'h6: top = tmr16_pkg::TOP_9BIT;
			4'h3, 4'h7: top = tmr16_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top = s_q.cmp_a;
			4'h8, 4'ha, 4'hc, 4'he: top = s_q.cap;
			default: top = tmr16_pkg::MAX_VAL;
		endcase
	end
	assign at_top = (s_q.count == top);

	// ==========================================================
	// Clock select and count tick
	logic [2:0] cs;
	logic count_tick;
	assign cs = s_q.ctrl_b[tmr16_pkg::CTRLB_CS +: 3];
	always_comb
	begin
		unique case (cs)
			3'h0: count_tick = 1'b0;
			3'h1: count_tick = 1'b1;
			3'h2: count_tick = (s_q.presc & tmr16_pkg::DIV8_MASK) == tmr16_pkg::DIV8_MASK;
			3'h3: count_tick = (s_q.presc & tmr16_pkg::DIV64_MASK) == tmr16_pkg::DIV64_MASK;
			3'h4: count_tick = (s_q.presc & tmr16_pkg::DIV256_MASK) == tmr16_pkg::DIV256_MASK;
			3'h5: count_tick = s_q.presc == tmr16_pkg::DIV1024_MASK;
			3'h6: count_tick = s_q.ext_prev && !ext_count_pin;
			default: count_tick = !s_q.ext_prev && ext_count_pin;
		endcase
	end

	// ==========================================================
	// Capture filter and edge
	logic cap_src, cap_filt, cap_fire;
	assign cap_src = s_q.ctrl_a[tmr16_pkg::CTRLA_CAP_SRC] ? comparator_in : capture_pin;
	// Four equal samples change the level when filtering
	assign cap_filt = !s_q.ctrl_b[tmr16_pkg::CTRLB_FILT] ? cap_src :
		(&s_q.cap_hist) ? 1'b1 : (~|s_q.cap_hist) ? 1'b0 : s_q.cap_lvl;
	assign cap_fire = (cap_filt != s_q.cap_lvl) && !icr_top &&
		(cap_filt == s_q.ctrl_b[tmr16_pkg::CTRLB_EDGE]);

	// ==========================================================
	// Bus access strobes
	logic rd_go, wr_go, wr_ok, match_a, match_b;
	logic [7:0] rd_addr, wr_addr, wbyte;
	assign rd_go = s_axi_arvalid && s_q.arready;
	assign wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
	assign wr_ok = wr_go && s_q.w_lane;
	assign rd_addr = {s_axi_araddr[7:2], 2'b00};
	assign wr_addr = {s_q.aw_addr[7:2], 2'b00};
	assign wbyte = s_q.w_data;
	assign match_a = count_tick && (s_q.count == s_q.cmp_a);
	assign match_b = count_tick && (s_q.count == s_q.cmp_b);

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [7:0] fset, fclr;
		logic mapped;
		fset = 8'h00;
		fclr = 8'h00;
		mapped = 1'b1;
		s_d = s_q;
		s_d.presc = s_q.presc + 10'h001;
		s_d.ext_prev = ext_count_pin;
		s_d.cap_hist = {s_q.cap_hist[tmr16_pkg::FILT_LEN-2:0], cap_src};
		s_d.cap_lvl = cap_filt;
		// Counting sequence and buffer reload
		if (count_tick)
		begin
			if (wgm != 4'h0 && at_top)
			begin
				s_d.count = tmr16_pkg::BOTTOM_VAL;
				fset[tmr16_pkg::FLG_OVF] = pwm_mode || (s_q.count == tmr16_pkg::MAX_VAL);
				if (pwm_mode)
				begin
					s_d.cmp_a = s_q.buf_a;
					s_d.cmp_b = s_q.buf_b;
				end
			end
			else
			begin
				s_d.count = s_q.count + 16'h0001;
				fset[tmr16_pkg::FLG_OVF] = (s_q.count == tmr16_pkg::MAX_VAL);
			end
		end
		fset[tmr16_pkg::FLG_MATCH_A] = match_a;
		fset[tmr16_pkg::FLG_MATCH_B] = match_b;
		// Waveform outputs
		if (pwm_mode)
		begin
			s_d.wave_a = !ocra_top && (s_q.count < s_q.cmp_a) &&
				s_q.ctrl_a[tmr16_pkg::CTRLA_OUT_A];
			s_d.wave_b = (s_q.count < s_q.cmp_b) && s_q.ctrl_a[tmr16_pkg::CTRLA_OUT_B];
		end
		else
		begin
			s_d.wave_a = s_q.wave_a ^ (match_a && s_q.ctrl_a[tmr16_pkg::CTRLA_OUT_A]);
			s_d.wave_b = s_q.wave_b ^ (match_b && s_q.ctrl_a[tmr16_pkg::CTRLA_OUT_B]);
		end
		// Capture copy and flag together
		if (cap_fire)
		begin
			s_d.cap = s_q.count;
			fset[tmr16_pkg::FLG_CAP] = 1'b1;
		end
		// Read channel
		if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
		else if (!s_q.arready && !s_q.rvalid)
			s_d.arready = 1'b1;
		if (rd_go)
		begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = 32'h00000000;
			unique case (rd_addr)
				tmr16_pkg::OFF_CNT_LO:
				begin
					s_d.rdata[7:0] = s_q.count[7:0];
					s_d.temp = s_q.count[15:8];
				end
				tmr16_pkg::OFF_CAP_LO:
				begin
					s_d.rdata[7:0] = s_q.cap[7:0];
					s_d.temp = s_q.cap[15:8];
				end
				tmr16_pkg::OFF_CNT_HI, tmr16_pkg::OFF_CAP_HI: s_d.rdata[7:0] = s_q.temp;
				tmr16_pkg::OFF_CMPA_LO: s_d.rdata[7:0] = s_q.buf_a[7:0];
				tmr16_pkg::OFF_CMPA_HI: s_d.rdata[7:0] = s_q.buf_a[15:8];
				tmr16_pkg::OFF_CMPB_LO: s_d.rdata[7:0] = s_q.buf_b[7:0];
				tmr16_pkg::OFF_CMPB_HI: s_d.rdata[7:0] = s_q.buf_b[15:8];
				tmr16_pkg::OFF_CTRL_A: s_d.rdata[7:0] = s_q.ctrl_a;
				tmr16_pkg::OFF_CTRL_B: s_d.rdata[7:0] = s_q.ctrl_b;
				tmr16_pkg::OFF_FLAGS: s_d.rdata[7:0] = s_q.flags;
				tmr16_pkg::OFF_MASK: s_d.rdata[7:0] = s_q.mask;
				default: mapped = 1'b0;
			endcase
			s_d.rresp = mapped ? tmr16_pkg::RESP_OKAY : tmr16_pkg::RESP_SLVERR;
		end
		// Write address and data capture
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end
		else if (!s_q.bvalid)
		begin
			s_d.awready = !s_q.aw_have;
			s_d.wready = !s_q.w_have;
		end
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr[7:0];
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane = s_axi_wstrb[0];
			s_d.wready = 1'b0;
		end
		// Register write, after read side effects
		if (wr_go)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = tmr16_pkg::RESP_OKAY;
			unique case (wr_addr)
				tmr16_pkg::OFF_CNT_HI, tmr16_pkg::OFF_CMPA_HI, tmr16_pkg::OFF_CMPB_HI,
				tmr16_pkg::OFF_CAP_HI:
					if (wr_ok) s_d.temp = wbyte;
				tmr16_pkg::OFF_CNT_LO:
					if (wr_ok) s_d.count = {s_q.temp, wbyte};
				tmr16_pkg::OFF_CMPA_LO: if (wr_ok) s_d.buf_a = {s_q.temp, wbyte};
				tmr16_pkg::OFF_CMPB_LO: if (wr_ok) s_d.buf_b = {s_q.temp, wbyte};
				tmr16_pkg::OFF_CAP_LO:
					if (wr_ok && icr_top) s_d.cap = {s_q.temp, wbyte};
				tmr16_pkg::OFF_CTRL_A: if (wr_ok) s_d.ctrl_a = wbyte;
				tmr16_pkg::OFF_CTRL_B: if (wr_ok) s_d.ctrl_b = wbyte;
				tmr16_pkg::OFF_FLAGS: if (wr_ok) fclr = wbyte;
				tmr16_pkg::OFF_MASK: if (wr_ok) s_d.mask = wbyte;
				default: s_d.bresp = tmr16_pkg::RESP_SLVERR;
			endcase
		end
		// Outside PWM the compares follow their buffers at once
		if (!pwm_mode)
		begin
			s_d.cmp_a = s_d.buf_a;
			s_d.cmp_b = s_d.buf_b;
		end
		// Set wins over write-one-to-clear
		s_d.flags = (s_q.flags & ~fclr) | fset;
		s_d.irq = |(s_q.flags & s_q.mask);
		s_d.at_bottom = (s_q.count == tmr16_pkg::BOTTOM_VAL);
		s_d.at_max = (s_q.count == tmr16_pkg::MAX_VAL);
	end

	// State register, all zero at reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from the state
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = s_q.rdata;
	assign wave_out_a = s_q.wave_a;
	assign wave_out_b = s_q.wave_b;
	assign irq_req = s_q.irq;
	assign at_bottom = s_q.at_bottom;
	assign at_max = s_q.at_max;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cnt_write_wins: assert property (
		wr_ok && wr_addr == tmr16_pkg::OFF_CNT_LO |=> s_q.count == $past({s_q.temp, wbyte})
	) else $error("counter write lost");
	a_temp_on_read: assert property (
		rd_go && rd_addr == tmr16_pkg::OFF_CNT_LO && !wr_go |=> s_q.temp == $past(s_q.count[15:8])
	) else $error("holding byte not loaded on read");
	a_cmp_read_direct: assert property (
		rd_go && rd_addr == tmr16_pkg::OFF_CMPA_HI && !wr_go
		|=> $stable(s_q.temp) && s_axi_rdata[7:0] == $past(s_q.buf_a[15:8])
	) else $error("compare read touched holding byte");
	a_stop_no_count: assert property (
		cs == 3'h0 && !(wr_ok && wr_addr == tmr16_pkg::OFF_CNT_LO) |=> $stable(s_q.count)
	) else $error("stopped counter moved");
	a_match_flag: assert property (
		match_a |=> s_q.flags[tmr16_pkg::FLG_MATCH_A]
	) else $error("match flag not set");
	a_capture_flag: assert property (
		cap_fire |=> s_q.flags[tmr16_pkg::FLG_CAP] && s_q.cap == $past(s_q.count)
	) else $error("capture flag and copy apart");
	a_cap_write_gate: assert property (
		wr_ok && wr_addr == tmr16_pkg::OFF_CAP_LO && !icr_top && !cap_fire |=> $stable(s_q.cap)
	) else $error("capture write not ignored");
	a_bottom_mark: assert property (
		s_q.count == tmr16_pkg::BOTTOM_VAL |=> at_bottom
	) else $error("bottom not flagged");
	a_irq_masked: assert property (
		s_q.mask == 8'h00 ##1 s_q.mask == 8'h00 |-> !irq_req
	) else $error("masked request raised");
	a_top_a_quiet: assert property (
		wgm == 4'hf ##1 wgm == 4'hf |-> !wave_out_a
	) else $error("top compare drove wave");

endmodule : tmr16_core

// *** test/tmr16_cpu_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Processor side: one bus access at a time, bytes in pairs
module tmr16_cpu_model (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	logic [1:0] resp;

	// Idle bus at time zero
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// One byte write; a single caller keeps pairs unbroken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
	begin
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		wdata <= ~{24'h0, d};
		@(posedge aclk);
	end
	endtask : wr

	// One byte read
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
	begin
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	end
	endtask : rd

	// Pair write, upper byte first so the holding byte is loaded
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
	begin
		wr(a + 8'h04, v[15:8], resp);
		wr(a, v[7:0], resp);
	end
	endtask : wr16

	// Pair read, lower byte first so the upper one is frozen
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
	begin
		rd(a, v[7:0], resp);
		rd(a + 8'h04, v[15:8], resp);
	end
	endtask : rd16
endmodule : tmr16_cpu_model

// *** test/tmr16_core_test.sv ***
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the timer core
module tmr16_core_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr, araddr, b;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic ext_pin = 1'b0, cap_pin = 1'b0, cmp_in = 1'b0;
	logic wave_a, wave_b, irq, bot, mx;
	logic saw_bot = 1'b0, saw_max = 1'b0, saw_clr = 1'b0;
	logic [15:0] v, c, got;
	int failures = 0, num_checks = 0, seed = 71096;

	// Clock, 8 ns period
	always #4 aclk = ~aclk;

	// Remember bottom and max markers until cleared
	always @(posedge aclk)
	begin
		saw_bot <= (saw_bot && !saw_clr) || bot;
		saw_max <= (saw_max && !saw_clr) || mx;
	end

	tmr16_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_count_pin(ext_pin), .capture_pin(cap_pin),
		.comparator_in(cmp_in), .wave_out_a(wave_a), .wave_out_b(wave_b),
		.irq_req(irq), .at_bottom(bot), .at_max(mx));

	tmr16_cpu_model u_cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Checking helpers
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
	begin
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	end
	endtask : chk

	// Top of the fixed-top modes
	function automatic logic [15:0] fixed_top(input int m);
		return m == 1 ? tmr16_pkg::TOP_8BIT : m == 2 ? tmr16_pkg::TOP_9BIT : tmr16_pkg::TOP_10BIT;
	endfunction : fixed_top

	task automatic test_done;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask : test_done

	// Hang guard
	initial
	begin
		#200000;
		failures++;
		test_done;
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 12; i++)
		begin
			u_cpu.rd(8'(i * 4), b, r);
			chk("reset value", 16'h0000, {r, 6'h0, b});
		end
		u_cpu.rd(8'h30, b, r);
		chk("unmapped read", {tmr16_pkg::RESP_SLVERR, 14'h0}, {r, 6'h0, b});
		u_cpu.wr(8'h30, 8'h5a, r);
		chk("unmapped write", 16'(tmr16_pkg::RESP_SLVERR), 16'(r));
		$display("test reset done");
		// Pair access on a stopped counter
		for (int k = 0; k < 4; k++)
		begin
			c = 16'($random(seed));
			u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, c);
			repeat (20) @(posedge aclk);
			u_cpu.rd16(tmr16_pkg::OFF_CNT_LO, got);
			chk("count pair", c, got);
		end
		// Holding byte shared across registers
		v = 16'($random(seed));
		u_cpu.wr(tmr16_pkg::OFF_CMPA_HI, v[15:8], r);
		u_cpu.wr(tmr16_pkg::OFF_CMPB_LO, v[7:0], r);
		u_cpu.rd16(tmr16_pkg::OFF_CMPB_LO, got);
		chk("shared holding", v, got);
		u_cpu.wr16(tmr16_pkg::OFF_CMPA_LO, ~c);
		u_cpu.rd(tmr16_pkg::OFF_CNT_LO, b, r);
		u_cpu.rd(tmr16_pkg::OFF_CMPA_HI, b, r);
		chk("compare high direct", {8'h0, ~c[15:8]}, {8'h0, b});
		u_cpu.rd(tmr16_pkg::OFF_CNT_HI, b, r);
		chk("holding untouched", {8'h0, c[15:8]}, {8'h0, b});
		$display("test pair access done");
		// Capture write refused outside capture-top modes
		u_cpu.wr16(tmr16_pkg::OFF_CAP_LO, ~c);
		u_cpu.rd16(tmr16_pkg::OFF_CAP_LO, got);
		chk("capture write ignored", 16'h0000, got);
		// Capture from pin, then from comparator through the filter
		for (int s = 0; s < 2; s++)
		begin
			c = 16'($random(seed));
			u_cpu.wr(tmr16_pkg::OFF_CTRL_A, 8'(s << 2), r);
			u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h40 | 8'(s << 7), r);
			u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, c);
			u_cpu.wr(tmr16_pkg::OFF_FLAGS, 8'hff, r);
			if (s == 0)
				cap_pin <= 1'b1;
			else
				cmp_in <= 1'b1;
			repeat (14) @(posedge aclk);
			u_cpu.rd16(tmr16_pkg::OFF_CAP_LO, got);
			chk("captured count", c, got);
			u_cpu.rd(tmr16_pkg::OFF_FLAGS, b, r);
			chk("capture flag", 16'h0020, {8'h0, b & 8'h20});
			u_cpu.wr(tmr16_pkg::OFF_FLAGS, 8'h20, r);
			u_cpu.rd(tmr16_pkg::OFF_FLAGS, b, r);
			chk("capture flag cleared", 16'h0000, {8'h0, b & 8'h20});
		end
		$display("test capture done");
		// External pin rising edges as count ticks
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h07, r);
		u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, c);
		repeat (3)
		begin
			repeat (4) @(posedge aclk);
			ext_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			ext_pin <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h00, r);
		u_cpu.rd16(tmr16_pkg::OFF_CNT_LO, got);
		chk("pin count", c + 16'h0003, got);
		// Overflow, match and interrupt mask
		u_cpu.wr(tmr16_pkg::OFF_CTRL_A, 8'h00, r);
		u_cpu.wr16(tmr16_pkg::OFF_CMPA_LO, 16'hfff8);
		u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, 16'hfff0);
		saw_clr <= 1'b1;
		@(posedge aclk);
		saw_clr <= 1'b0;
		u_cpu.wr(tmr16_pkg::OFF_FLAGS, 8'hff, r);
		u_cpu.wr(tmr16_pkg::OFF_MASK, 8'h03, r);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h01, r);
		repeat (40) @(posedge aclk);
		// Pair write while counting at the clock rate
		c = 16'($random(seed));
		u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, c);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h00, r);
		u_cpu.rd16(tmr16_pkg::OFF_CNT_LO, got);
		chk("write beats count", 16'h0001, {15'h0, (got - c) < 16'h0008});
		u_cpu.rd(tmr16_pkg::OFF_FLAGS, b, r);
		chk("overflow and match", 16'h0003, {8'h0, b & 8'h03});
		chk("irq raised", 16'h0001, {15'h0, irq});
		chk("max and bottom", 16'h0003, {14'h0, saw_max, saw_bot});
		u_cpu.wr(tmr16_pkg::OFF_MASK, 8'h00, r);
		repeat (2) @(posedge aclk);
		chk("irq masked", 16'h0000, {15'h0, irq});
		$display("test overflow done");
		// Fixed tops and the compare B output
		for (int m = 1; m < 4; m++)
		begin
			u_cpu.wr(tmr16_pkg::OFF_CTRL_A, 8'h40 | 8'(m), r);
			u_cpu.wr16(tmr16_pkg::OFF_CMPB_LO, 16'h0080);
			u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, fixed_top(m) - 16'h0004);
			u_cpu.wr(tmr16_pkg::OFF_FLAGS, 8'hff, r);
			u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h01, r);
			repeat (12) @(posedge aclk);
			u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h00, r);
			u_cpu.rd16(tmr16_pkg::OFF_CNT_LO, got);
			chk("wrap at top", 16'h0001, {15'h0, got < 16'h0020});
			chk("wave below compare", 16'h0001, {15'h0, wave_b});
		end
		// Capture register as top, then compare A as top
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h18, r);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_A, 8'h12, r);
		u_cpu.wr16(tmr16_pkg::OFF_CAP_LO, 16'h0040);
		u_cpu.rd16(tmr16_pkg::OFF_CAP_LO, got);
		chk("capture written as top", 16'h0040, got);
		u_cpu.wr16(tmr16_pkg::OFF_CMPA_LO, 16'h0030);
		u_cpu.wr16(tmr16_pkg::OFF_CNT_LO, 16'h003c);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h19, r);
		repeat (12) @(posedge aclk);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_A, 8'h13, r);
		repeat (80) @(posedge aclk);
		u_cpu.wr(tmr16_pkg::OFF_CTRL_B, 8'h18, r);
		u_cpu.rd16(tmr16_pkg::OFF_CNT_LO, got);
		chk("wrap at compare top", 16'h0001, {15'h0, got <= 16'h0030});
		chk("no wave from top compare", 16'h0000, {15'h0, wave_a});
		$display("test top done");
		test_done;
	end
endmodule : tmr16_core_test
